// ==== cccr_pkg.sv ====
// Package for the cache and capability configuration register pair.
// Assumes a single core clock domain and coprocessor-style move access.
package cccr_pkg;

    // ------------------------------------------------------------
    // Register selects on the coprocessor move port
    // ------------------------------------------------------------
    localparam logic [4:0] CCCR_REG_NUM      = 5'h10;  // Config register group
    localparam logic [2:0] CCCR_SEL_HIER     = 3'h2;   // cache_hierarchy_config
    localparam logic [2:0] CCCR_SEL_EXT      = 3'h3;   // extended_capability_config

    // ------------------------------------------------------------
    // cache_hierarchy_config field positions
    // ------------------------------------------------------------
    localparam int HIER_MORE_BIT  = 31;  // Next register present flag
    localparam int HIER_TU_LSB    = 28;  // Tertiary impl bits (3 wide)
    localparam int HIER_TS_LSB    = 24;  // Tertiary sets per way
    localparam int HIER_TL_LSB    = 20;  // Tertiary line size
    localparam int HIER_TA_LSB    = 16;  // Tertiary associativity
    localparam int HIER_SU_LSB    = 12;  // Secondary impl bits
    localparam int HIER_SS_LSB    = 8;   // Secondary sets per way
    localparam int HIER_SL_LSB    = 4;   // Secondary line size
    localparam int HIER_SA_LSB    = 0;   // Secondary associativity

    // ------------------------------------------------------------
    // extended_capability_config field positions
    // ------------------------------------------------------------
    localparam int EXT_MORE_BIT   = 31;
    localparam int EXT_DSP_BIT    = 10;
    localparam int EXT_LPA_BIT    = 7;
    localparam int EXT_EIC_BIT    = 6;
    localparam int EXT_VECTORED_IRQ_PRESENT_BIT   = 5;
    localparam int EXT_SP_BIT     = 4;
    localparam int EXT_MT_BIT     = 2;
    localparam int EXT_SM_BIT     = 1;
    localparam int EXT_TRACE_BIT  = 0;

    // Only these bits may ever be one in the capability register
    localparam logic [31:0] EXT_DEFINED_MASK = 32'h0000_04f7;
    // Bits forced low on a first-release implementation
    localparam logic [31:0] EXT_REL2_MASK    = 32'h0000_00f0;

    // ------------------------------------------------------------
    // Encoding limits
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_MAX_VALID = 4'h7;  // 8..15 reserved
    localparam logic [3:0] SU_RESET       = 4'h0;  // Impl field after reset

endpackage

// ==== cccr_field_if.sv ====
// Interface carrying the secondary implementation field between modules.
// Assumes both ends are in the core clock domain.
`timescale 1ns/1ns
interface cccr_field_if;
    logic       wrEn;    // Write strobe for the field
    logic [3:0] wrData;  // Value to store
    logic [3:0] rdData;  // Stored value, from a flip-flop

    modport owner (input wrEn, input wrData, output rdData);
    modport user  (output wrEn, output wrData, input rdData);
endinterface

// ==== cccr_impl_field.sv ====
// Secondary-cache implementation-specific field storage.
// Assumes writes arrive as one-cycle strobes from the register bank.
`timescale 1ns/1ns
module cccr_impl_field
    import cccr_pkg::*;
#(
    parameter bit IMPLEMENTED = 1'b1  // Field exists in this build
) (
    input  wire logic   core_clk,
    input  wire logic   resetn,
    input  wire logic   clkEn,
    cccr_field_if.owner fld
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [3:0] field_q;  // Stored bits
    logic [3:0] field_d;  // Next value

    // Absent field drops writes and stays zero
    always_comb begin
        field_d = field_q;
        if (fld.wrEn && IMPLEMENTED) begin
            field_d = fld.wrData;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            field_q <= SU_RESET;
        end else if (clkEn) begin
            field_q <= field_d;
        end
    end

    assign fld.rdData = IMPLEMENTED ? field_q : 4'h0;

    absent_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !IMPLEMENTED |-> fld.rdData == 4'h0)
        else $error("absent impl field not zero");
endmodule

// ==== cccr_regs.sv ====
// Cache hierarchy and extended capability configuration register bank.
// Assumes the core issues coprocessor move reads and writes as one-cycle
// strobes with register number and select, all synchronous to core_clk.
`timescale 1ns/1ns

module cccr_regs
    import cccr_pkg::*;
#(
    parameter logic [3:0] TS_CODE      = 4'h0,  // Tertiary sets code
    parameter logic [3:0] TL_CODE      = 4'h0,  // Tertiary line code, 0 = none
    parameter logic [3:0] TA_CODE      = 4'h0,  // Tertiary associativity
    parameter logic [3:0] SS_CODE      = 4'h2,  // Secondary sets code
    parameter logic [3:0] SL_CODE      = 4'h5,  // Secondary line code
    parameter logic [3:0] SA_CODE      = 4'h3,  // Secondary associativity
    parameter bit         SU_PRESENT   = 1'b1,  // Impl field exists
    parameter bit         RELEASE2     = 1'b1,  // Second architecture release
    parameter bit         HAS_DSP      = 1'b0,
    parameter bit         HAS_LPA      = 1'b0,
    parameter bit         HAS_EIC      = 1'b0,  // Mode supported and attached
    parameter bit         HAS_VECTORED_IRQ_PRESENT     = 1'b1,
    parameter bit         HAS_SP       = 1'b0,
    parameter bit         HAS_MT       = 1'b0,
    parameter bit         HAS_SM       = 1'b0,
    parameter bit         HAS_TRACE    = 1'b0
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic        moveRd,
    input  wire logic        moveWr,
    input  wire logic [4:0]  moveRegNum,
    input  wire logic [2:0]  moveSel,
    input  wire logic [31:0] moveWrData,
    output logic      [31:0] moveRdData,
    output logic             moveRdValid,
    output logic             moveHit
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Clamp reserved codes to zero so a bad preset never leaks
    function automatic logic [3:0] validCode(input logic [3:0] c);
        return (c > CODE_MAX_VALID) ? 4'h0 : c;
    endfunction

    // Register select match, used by read and write paths
    function automatic logic selIs(input logic [4:0] r, input logic [2:0] s,
                                   input logic [2:0] want);
        return (r == CCCR_REG_NUM) && (s == want);
    endfunction

    // ------------------------------------------------------------
    // Field carrier to the implementation-field store
    // ------------------------------------------------------------
    cccr_field_if suBus ();

    logic hierSel;  // Access targets hierarchy register
    logic extSel;   // Access targets capability register

    assign hierSel = selIs(moveRegNum, moveSel, CCCR_SEL_HIER);
    assign extSel  = selIs(moveRegNum, moveSel, CCCR_SEL_EXT);
    assign moveHit = hierSel | extSel;

    // Only the impl bits ever take a write; all else is preset
    assign suBus.wrEn   = moveWr && hierSel;
    assign suBus.wrData = moveWrData[HIER_SU_LSB +: 4];

    cccr_impl_field #(
        .IMPLEMENTED (SU_PRESENT)
    ) u_su (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .fld      (suBus)
    );

    // ------------------------------------------------------------
    // Preset images
    // ------------------------------------------------------------
    logic [31:0] hierImage;  // Hierarchy register as read
    logic [31:0] extImage;   // Capability register as read
    logic [31:0] extRaw;     // Capability before release masking

    // Tertiary impl bits unimplemented; no further register flag
    always_comb begin
        hierImage = 32'h0;
        hierImage[HIER_TS_LSB +: 4] = validCode(TS_CODE);
        hierImage[HIER_TL_LSB +: 4] = validCode(TL_CODE);
        hierImage[HIER_TA_LSB +: 4] = validCode(TA_CODE);
        hierImage[HIER_SU_LSB +: 4] = suBus.rdData;
        hierImage[HIER_SS_LSB +: 4] = validCode(SS_CODE);
        hierImage[HIER_SL_LSB +: 4] = validCode(SL_CODE);
        hierImage[HIER_SA_LSB +: 4] = validCode(SA_CODE);
    end

    // Capability flags straight from presets
    always_comb begin
        extRaw = 32'h0;
        extRaw[EXT_DSP_BIT]   = HAS_DSP;
        extRaw[EXT_LPA_BIT]   = HAS_LPA;
        extRaw[EXT_EIC_BIT]   = HAS_EIC;
        extRaw[EXT_VECTORED_IRQ_PRESENT_BIT]  = HAS_VECTORED_IRQ_PRESENT;
        extRaw[EXT_SP_BIT]    = HAS_SP;
        extRaw[EXT_MT_BIT]    = HAS_MT;
        extRaw[EXT_SM_BIT]    = HAS_SM;
        extRaw[EXT_TRACE_BIT] = HAS_TRACE;
    end

    // Reserved and more-flag bits masked; release 1 drops four flags
    assign extImage = extRaw & EXT_DEFINED_MASK
                      & (RELEASE2 ? 32'hffff_ffff : ~EXT_REL2_MASK);

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic        rdValid_q;
    logic        rdValid_d;

    // Unmapped selects read zero; writes to capability ignored
    always_comb begin
        rdData_d  = rdData_q;
        rdValid_d = 1'b0;
        if (moveRd) begin
            rdValid_d = 1'b1;
            if (hierSel) begin
                rdData_d = hierImage;
            end else if (extSel) begin
                rdData_d = extImage;
            end else begin
                rdData_d = 32'h0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdData_q  <= 32'h0;
            rdValid_q <= 1'b0;
        end else if (clkEn) begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign moveRdData  = rdData_q;
    assign moveRdValid = rdValid_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence extReadSeq;
        moveRd && extSel && clkEn;
    endsequence

    sequence hierReadSeq;
        moveRd && hierSel && clkEn;
    endsequence

    sequence hierWriteSeq;
        moveWr && hierSel && clkEn;
    endsequence

    sequence extWriteSeq;
        moveWr && extSel && clkEn;
    endsequence

    // Codes as software must read them; reserved presets read zero
    localparam logic [3:0] TS_RD = (TS_CODE > CODE_MAX_VALID) ? 4'h0 : TS_CODE;
    localparam logic [3:0] TL_RD = (TL_CODE > CODE_MAX_VALID) ? 4'h0 : TL_CODE;
    localparam logic [3:0] TA_RD = (TA_CODE > CODE_MAX_VALID) ? 4'h0 : TA_CODE;
    localparam logic [3:0] SS_RD = (SS_CODE > CODE_MAX_VALID) ? 4'h0 : SS_CODE;
    localparam logic [3:0] SL_RD = (SL_CODE > CODE_MAX_VALID) ? 4'h0 : SL_CODE;
    localparam logic [3:0] SA_RD = (SA_CODE > CODE_MAX_VALID) ? 4'h0 : SA_CODE;

    // Capability word built bit by bit, independent of the image logic
    localparam logic [31:0] EXT_EXPECT = {21'h0, HAS_DSP, 2'b00,
        HAS_LPA & RELEASE2, HAS_EIC & RELEASE2, HAS_VECTORED_IRQ_PRESENT & RELEASE2, HAS_SP & RELEASE2,
        1'b0, HAS_MT, HAS_SM, HAS_TRACE};

    ext_readonly_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdValid && moveRdData == EXT_EXPECT)
        else $error("capability read mismatch");

    more_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> !moveRdData[EXT_MORE_BIT])
        else $error("capability more bit set");

    ext_reserved_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> (moveRdData & ~EXT_DEFINED_MASK) == 32'h0)
        else $error("reserved capability bit set");

    rel1_mask_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> RELEASE2 || moveRdData[7:4] == 4'h0)
        else $error("release one flags not cleared");

    trace_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_TRACE_BIT] == HAS_TRACE)
        else $error("trace flag wrong");

    sets_code_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierReadSeq |=> moveRdData[HIER_SS_LSB +: 4] <= CODE_MAX_VALID)
        else $error("secondary sets code reserved");

    line_code_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierReadSeq |=> moveRdData[HIER_SL_LSB +: 4] <= CODE_MAX_VALID
                        && moveRdData[HIER_TL_LSB +: 4] <= CODE_MAX_VALID)
        else $error("line size code reserved");

    preset_stable_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierWriteSeq ##1 hierReadSeq |=>
            moveRdData[11:0] == {SS_RD, SL_RD, SA_RD}
            && moveRdData[31:16] == {4'h0, TS_RD, TL_RD, TA_RD})
        else $error("preset field changed by write");

    su_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierWriteSeq |=> !SU_PRESENT
            || {16'h0, suBus.rdData, 12'h000} == ($past(moveWrData) & 32'h0000_f000))
        else $error("impl field write lost");

    // ------------------------------------------------------------
    // Field value checks against the presets
    // ------------------------------------------------------------
    // Each field but tertiary sets is held against its own preset, not the image,
    // so a slice placed at the wrong position shows up here

    // Secondary sets per way
    sets_value_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierReadSeq |=> moveRdData[HIER_SS_LSB +: 4] == SS_RD)
        else $error("secondary sets code wrong");

    // Secondary line size, zero when absent
    sline_value_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierReadSeq |=> moveRdData[HIER_SL_LSB +: 4] == SL_RD)
        else $error("secondary line code wrong");

    // Both associativity fields
    assoc_value_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierReadSeq |=> moveRdData[HIER_SA_LSB +: 4] == SA_RD
                        && moveRdData[HIER_TA_LSB +: 4] == TA_RD)
        else $error("associativity code wrong");

    // Tertiary line size, zero when absent
    tline_value_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierReadSeq |=> moveRdData[HIER_TL_LSB +: 4] == TL_RD)
        else $error("tertiary line code wrong");

    // Tertiary impl bits and more flag are not provided
    hier_top_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierReadSeq |=> moveRdData[31:28] == 4'h0)
        else $error("hierarchy top bits set");

    // ------------------------------------------------------------
    // Capability flag checks
    // ------------------------------------------------------------
    // Flags with no release condition
    dsp_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_DSP_BIT] == HAS_DSP)
        else $error("signal ext flag wrong");

    mt_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_MT_BIT] == HAS_MT)
        else $error("multithread flag wrong");

    sm_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_SM_BIT] == HAS_SM)
        else $error("security flag wrong");

    // Flags that only a second-release build may show
    lpa_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_LPA_BIT] == (HAS_LPA && RELEASE2))
        else $error("large address flag wrong");

    eic_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_EIC_BIT] == (HAS_EIC && RELEASE2))
        else $error("ext irq ctrl flag wrong");

    vectored_irq_present_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_VECTORED_IRQ_PRESENT_BIT] == (HAS_VECTORED_IRQ_PRESENT && RELEASE2))
        else $error("vectored irq flag wrong");

    sp_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extReadSeq |=> moveRdData[EXT_SP_BIT] == (HAS_SP && RELEASE2))
        else $error("small page flag wrong");

    // ------------------------------------------------------------
    // Write, hold and decode checks
    // ------------------------------------------------------------
    // Missing impl field drops the write
    su_absent_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hierWriteSeq |=> SU_PRESENT || suBus.rdData == 4'h0)
        else $error("absent impl field took write");

    // Capability write must not reach the impl field
    ext_wr_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn)
        extWriteSeq |=> $stable(suBus.rdData))
        else $error("capability write had effect");

    // Low clock enable freezes every flop
    freeze_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !clkEn |=> $stable(moveRdData) && $stable(moveRdValid)
                   && $stable(suBus.rdData))
        else $error("state moved while frozen");

    // Valid lasts one cycle only
    valid_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (clkEn && !moveRd) |=> !moveRdValid)
        else $error("read valid stretched");

    // Read data holds between reads
    rd_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (clkEn && !moveRd) |=> $stable(moveRdData))
        else $error("read data moved without read");

    // Unmapped selects answer zero
    unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (moveRd && !moveHit && clkEn) |=> moveRdValid && moveRdData == 32'h0)
        else $error("unmapped read not zero");

    // Hit only for the two mapped selects
    hit_decode_a: assert property (@(posedge core_clk) disable iff (!resetn)
        moveHit == (moveRegNum == CCCR_REG_NUM
                    && (moveSel == CCCR_SEL_HIER || moveSel == CCCR_SEL_EXT)))
        else $error("register hit decode wrong");
endmodule

// ==== tb_cccr_regs.sv ====
// Self-checking testbench for the cache and capability register bank.
// Assumes cccr_pkg, cccr_field_if, cccr_impl_field and cccr_regs compile first.
`timescale 1ns/1ns
module tb_cccr_regs import cccr_pkg::*;;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        coreClk;     // 250 MHz core clock
    logic        resetn;      // Active-low reset
    logic        clkEn;       // Clock enable
    logic        moveRd;      // Read strobe
    logic        moveWr;      // Write strobe
    logic [4:0]  moveRegNum;  // Register number
    logic [2:0]  moveSel;     // Register select
    logic [31:0] moveWrData;  // Write data
    logic [31:0] rdA, rdB;    // Read data of each build
    logic        vldA, vldB;  // Read valid of each build
    logic        hitA;        // Address decode of default build
    int          badCount;    // Mismatches seen
    int          numChecks;   // Comparisons made
    // Default build image: SS=2, SL=5, SA=3, vectored irq only
    localparam logic [31:0] HIER_A = 32'h0000_0253;
    localparam logic [31:0] EXT_A  = 32'h1 << EXT_VECTORED_IRQ_PRESENT_BIT;
    // Release-1 build: all features on, tertiary 7/7/7, reserved SS clamped
    localparam logic [31:0] HIER_B = 32'h0777_0010;
    localparam logic [31:0] EXT_B  = (32'h1 << EXT_DSP_BIT) | (32'h1 << EXT_MT_BIT)
                                   | (32'h1 << EXT_SM_BIT) | (32'h1 << EXT_TRACE_BIT);
    // Release-1 build presets; vectored irq left at its default of one
    localparam logic [3:0] R1_TERT = 4'h7;
    localparam logic [3:0] R1_SS   = 4'h9;
    localparam logic [3:0] R1_SL   = 4'h1;
    localparam logic [3:0] R1_SA   = 4'h0;
    localparam bit         R1_ON   = 1'b1;
    localparam bit         R1_OFF  = 1'b0;
    // ------------------------------------------------------------
    // Two builds share the stimulus so release-1 forcing is visible
    // ------------------------------------------------------------
    cccr_regs uut (.core_clk(coreClk), .resetn(resetn), .clkEn(clkEn), .moveRd(moveRd),
        .moveWr(moveWr), .moveRegNum(moveRegNum), .moveSel(moveSel),
        .moveWrData(moveWrData), .moveRdData(rdA), .moveRdValid(vldA), .moveHit(hitA));
    cccr_regs #(.TS_CODE(R1_TERT), .TL_CODE(R1_TERT), .TA_CODE(R1_TERT), .SS_CODE(R1_SS),
        .SL_CODE(R1_SL), .SA_CODE(R1_SA), .SU_PRESENT(R1_OFF), .RELEASE2(R1_OFF),
        .HAS_DSP(R1_ON), .HAS_LPA(R1_ON), .HAS_EIC(R1_ON), .HAS_SP(R1_ON),
        .HAS_MT(R1_ON), .HAS_SM(R1_ON), .HAS_TRACE(R1_ON)) uutRel1 (.core_clk(coreClk),
        .resetn(resetn), .clkEn(clkEn), .moveRd(moveRd), .moveWr(moveWr),
        .moveRegNum(moveRegNum), .moveSel(moveSel), .moveWrData(moveWrData),
        .moveRdData(rdB), .moveRdValid(vldB), .moveHit());
    // Clock: invert every half period
    always #2 coreClk = ~coreClk;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compare and count; unknowns never match
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single closing point for the run
    task automatic finishTest();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One-cycle read strobe, then bounded wait for the valid pulse
    task automatic rdReg(input logic [2:0] sel);
        int n;
        @(posedge coreClk);
        moveRd     <= 1'b1;
        moveRegNum <= CCCR_REG_NUM;
        moveSel    <= sel;
        @(posedge coreClk);
        moveRd <= 1'b0;
        n = 0;
        #1;
        while (vldA !== 1'b1 && n < 4) begin
            @(posedge coreClk);
            #1;
            n++;
        end
        if (vldA !== 1'b1) begin
            badCount++;
            finishTest();
        end
        chk({31'h0, vldB}, 32'h1);
    endtask
    // One-cycle write strobe; writes carry no answer
    task automatic wrReg(input logic [2:0] sel, input logic [31:0] data);
        @(posedge coreClk);
        moveWr     <= 1'b1;
        moveRegNum <= CCCR_REG_NUM;
        moveSel    <= sel;
        moveWrData <= data;
        @(posedge coreClk);
        moveWr <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Preset images of both registers in both builds
    task automatic tPresets();
        rdReg(CCCR_SEL_HIER);
        chk(rdA, HIER_A);
        chk(rdB, HIER_B);
        rdReg(CCCR_SEL_EXT);
        chk(rdA, EXT_A);
        chk(rdB, EXT_B);
        $display("test presets done");
    endtask
    // Only the impl field takes writes; a missing field stays zero
    task automatic tImplField();
        wrReg(CCCR_SEL_HIER, 32'hffff_ffff);
        rdReg(CCCR_SEL_HIER);
        chk(rdA, HIER_A | 32'h0000_f000);
        chk(rdB, HIER_B);
        // Read right behind a write must see the new bits
        @(posedge coreClk);
        moveWr     <= 1'b1;
        moveWrData <= 32'h0000_5000;
        @(posedge coreClk);
        moveWr <= 1'b0;
        moveRd <= 1'b1;
        @(posedge coreClk);
        moveRd <= 1'b0;
        #1;
        chk({31'h0, vldA}, 32'h1);
        chk(rdA, HIER_A | 32'h0000_5000);
        // Mid-run reset clears the field again
        @(posedge coreClk);
        resetn <= 1'b0;
        repeat (2) @(posedge coreClk);
        chk(rdA, 32'h0);
        chk({31'h0, vldA | vldB}, 32'h0);
        resetn <= 1'b1;
        rdReg(CCCR_SEL_HIER);
        chk(rdA, HIER_A);
        $display("test impl field done");
    endtask
    // Capability register ignores every write
    task automatic tReadOnly();
        wrReg(CCCR_SEL_EXT, EXT_DEFINED_MASK);
        rdReg(CCCR_SEL_EXT);
        chk(rdA, EXT_A);
        chk(rdB, EXT_B);
        $display("test read only done");
    endtask
    // Unmapped select reads zero; frozen clock enable drops requests
    task automatic tUnmappedHold();
        rdReg(3'h5);
        chk(rdA, 32'h0);
        chk({31'h0, hitA}, 32'h0);
        @(posedge coreClk);
        clkEn <= 1'b0;
        wrReg(CCCR_SEL_HIER, 32'h0000_a000);
        @(posedge coreClk);
        moveRd  <= 1'b1;
        moveSel <= CCCR_SEL_HIER;
        @(posedge coreClk);
        moveRd <= 1'b0;
        #1;
        chk({31'h0, vldA}, 32'h0);
        chk({31'h0, hitA}, 32'h1);
        @(posedge coreClk);
        clkEn <= 1'b1;
        rdReg(CCCR_SEL_HIER);
        chk(rdA, HIER_A);
        $display("test unmapped and hold done");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        coreClk    = 1'b0;
        resetn     = 1'b0;
        clkEn      = 1'b1;
        moveRd     = 1'b0;
        moveWr     = 1'b0;
        moveRegNum = 5'h00;
        moveSel    = 3'h0;
        moveWrData = 32'h0;
        badCount   = 0;
        numChecks  = 0;
        repeat (4) @(posedge coreClk);
        resetn <= 1'b1;
        tPresets();
        tImplField();
        tReadOnly();
        tUnmappedHold();
        finishTest();
    end
endmodule
